// file: dv/ipfb_tb.sv
// Self-checking bench for the filter binding block
`include "ipfb_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // One register access: byte address, write data, expected readback
  typedef struct {
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } ipfb_row_t;

  // Bus, filter and bookkeeping signals
  logic                hclk;
  logic                hresetn;
  logic                hsel;
  logic                hwrite;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [31:0]         haddr;
  logic [31:0]         hwdata;
  logic [31:0]         hrdata;
  logic                hreadyout;
  logic                hresp;
  ipfb_pkg::ipfb_hit_t hit_v4;
  ipfb_pkg::ipfb_hit_t hit_v6;
  ipfb_pkg::ipfb_vec_t pass_v4;
  ipfb_pkg::ipfb_vec_t pass_v6;
  ipfb_pkg::ipfb_vec_t b4;
  ipfb_pkg::ipfb_vec_t b6;
  int                  err_count = 0;
  int                  checked = 0;
  logic [31:0]         regs [4] = '{32'h0000_00A8, 32'h0000_00AC, 32'h0000_00C8, 32'h0000_00CC};

  // Ordinary accesses; all-ones writes expose the reserved holes
  ipfb_row_t rows [6] = '{
    '{32'h0000_00A8, 32'hFFFF_FFFF, 32'h0000_D7FF},
    '{32'h0000_00AC, 32'hFFFF_FFFF, 32'h0000_FFFF},
    '{32'h0000_00C8, 32'hFFFF_FFFF, 32'h0000_F7FF},
    '{32'h0000_00CC, 32'hFFFF_FFFF, 32'h0000_BFFF},
    '{32'h0000_00B0, 32'hFFFF_FFFF, 32'h0000_0000},
    '{32'h0000_00A8, 32'h0000_5555, 32'h0000_5555}
  };

  // Single slave, so its ready is the bus ready
  ipfb_filter_bind DUT (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hreadyout),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hit_v4    (hit_v4),
    .hit_v6    (hit_v6),
    .pass_v4   (pass_v4),
    .pass_v6   (pass_v6)
  );

  // 10 MHz clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Hang guard, well beyond the roughly 530 cycles the run needs
  initial begin
    #(100 * 5000);
    err_count++;
    final_report();
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // One single transfer; waits on ready in both phases
  task automatic ahb_xfer(input logic [31:0] a, input logic w, input logic [2:0] sz,
                          input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // Hits applied after one edge, gated result seen after the next
  task automatic gate(input logic [31:0] h, input logic m4, input logic m6);
    @(posedge hclk);
    hit_v4 <= {m4, h};
    hit_v6 <= {m6, h};
    @(posedge hclk);
    #1;
    chk("pass_v4", h & (~b4 | {32{m4}}), pass_v4);
    chk("pass_v6", h & (~b6 | {32{m6}}), pass_v6);
  endtask

  // Passes, hresp and registers at zero, hreadyout high, right after reset
  task automatic reset_check;
    logic [31:0] r;
    chk("pass_v4", 32'h0000_0000, pass_v4);
    chk("pass_v6", 32'h0000_0000, pass_v6);
    chk("hreadyout", 32'h0000_0001, {31'h0, hreadyout});
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
    for (int i = 0; i < 4; i++) begin
      ahb_xfer(regs[i], 1'b0, 3'h2, 32'h0000_0000, r);
      chk("reset_value", 32'h0000_0000, r);
    end
  endtask

  task automatic final_report;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [31:0] r;
    logic [31:0] v;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    hit_v4 = '0;
    hit_v6 = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reset_check();
    $display("test reset values done");
    // Walking one across both vectors; each bit gates only its own filter
    for (int i = 0; i < 32; i++) begin
      v = 32'h0000_0001 << i;
      ahb_xfer(regs[0], 1'b1, 3'h2, {16'h0, v[15:0]}, r);
      ahb_xfer(regs[1], 1'b1, 3'h2, {16'h0, v[31:16]}, r);
      ahb_xfer(regs[2], 1'b1, 3'h2, {16'h0, v[15:0]}, r);
      ahb_xfer(regs[3], 1'b1, 3'h2, {16'h0, v[31:16]}, r);
      b4 = v & 32'hFFFF_D7FF;
      b6 = v & 32'hBFFF_F7FF;
      gate(32'hFFFF_FFFF, 1'b0, 1'b0);
    end
    $display("test walking enable done");
    // Register table: write then read back each row
    foreach (rows[i]) begin
      ahb_xfer(rows[i].a, 1'b1, 3'h2, rows[i].d, r);
      ahb_xfer(rows[i].a, 1'b0, 3'h2, 32'h0000_0000, r);
      chk("readback", rows[i].e, r);
    end
    $display("test register table done");
    // Mixed hits with address match on one side only
    b4 = 32'hFFFF_5555;
    b6 = 32'hBFFF_F7FF;
    gate(32'hFFFF_FFFF, 1'b1, 1'b0);
    gate(32'h5A5A_A5A5, 1'b0, 1'b1);
    $display("test mixed match done");
    // A byte-sized write must leave the register alone
    ahb_xfer(regs[0], 1'b1, 3'h0, 32'h0000_0000, r);
    ahb_xfer(regs[0], 1'b0, 3'h2, 32'h0000_0000, r);
    chk("byte_write", 32'h0000_5555, r);
    $display("test byte size done");
    // Reset in mid-run clears every enable
    @(posedge hclk);
    hit_v4 <= '0;
    hit_v6 <= '0;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reset_check();
    $display("test mid-run reset done");
    final_report();
  end
endmodule

// file: hw/ipfb_ahb_front.sv
// AHB-Lite address-phase decode and write data-phase tracking
`include "ipfb_defs.svh"
module ipfb_ahb_front (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Address phase
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  // Decoded access
  output logic             acc_rd,
  output logic [7:0]       acc_idx,
  output logic             wr_pend,
  output logic [7:0]       wr_idx
);

  ipfb_pkg::ipfb_bus_st_t st_r;
  ipfb_pkg::ipfb_bus_st_t st_nxt;
  logic                   acc;

  // Only aligned word accesses in the low window are decoded
  assign acc     = hsel && htrans[1] && hready && (haddr[31:10] == 22'h0)
                   && (haddr[1:0] == 2'h0) && (hsize == `IPFB_HSIZE_WORD);
  assign acc_idx = haddr[9:2];
  assign acc_rd  = acc && !hwrite;
  assign wr_pend = st_r.wr_pend;
  assign wr_idx  = st_r.wr_idx;

  // Remember a write so its data can be taken in the data phase
  always_comb begin
    st_nxt         = st_r;
    st_nxt.wr_pend = acc && hwrite;
    if (acc && hwrite) begin
      st_nxt.wr_idx = acc_idx;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// file: hw/ipfb_defs.svh
// Register indices, field positions, write masks and reset values of the binding block
`ifndef IPFB_DEFS_SVH
`define IPFB_DEFS_SVH

// Register indices; the byte address is four times the index
`define IPFB_IDX_V4_LO     8'h2A
`define IPFB_IDX_V4_HI     8'h2B
`define IPFB_IDX_V6_LO     8'h32
`define IPFB_IDX_V6_HI     8'h33

// Writable bits of each 16-bit half; reserved bits stay zero
`define IPFB_V4_LO_MASK    16'hD7FF
`define IPFB_V4_HI_MASK    16'hFFFF
`define IPFB_V6_LO_MASK    16'hF7FF
`define IPFB_V6_HI_MASK    16'hBFFF

// Reset value of both binding vectors
`define IPFB_BIND_RST      32'h0000_0000

// Field positions inside a binding vector
`define IPFB_TCP_LSB       0
`define IPFB_TCP_MSB       10
`define IPFB_UDP_FIRST     12
`define IPFB_DHCP6         13
`define IPFB_EAP_UDP       14
`define IPFB_NAME_SVC      15
`define IPFB_FLEX_LSB      16
`define IPFB_FLEX_MSB      27
`define IPFB_RANGE         28
`define IPFB_ICMP          29
`define IPFB_ARP           30
`define IPFB_RMCP          31

// Bus decode values
`define IPFB_HSIZE_WORD    3'h2
`define IPFB_RESP_OKAY     1'b0

`endif

// file: hw/ipfb_filter_bind.sv
// Binding of receive port/protocol filters to IPv4 and IPv6 address filters
// Function
// R01: IPv4 bits 0-10 bind TCP port filters
// R02: IPv4 bit 12 binds first UDP filter
// R03: IPv4 bit 14 binds EAP-over-UDP filter
// R04: IPv4 bit 15 binds name service filter
// R05: IPv4 bits 16-27 bind flexible port filters
// R06: Next bit binds the range port filter
// R07: IPv4 bit 29 binds ICMPv4 filter
// R08: IPv4 bit 30 binds ARP requests and responses
// R09: IPv4 bit 31 binds RMCP filter
// R10: IPv4 vector sits in registers 42 and 43
// R11: IPv6 vector sits in registers 50 and 51
// R12: IPv6 bits 0-8 bind TCP port filters
// R13: IPv6 upper bits bind remaining filters likewise
// R14: Clear bit leaves filter unaffected by address
// R15: Reserved bits read zero; all reset zero
//
// The AHB-Lite interface to the registers was chosen for this implementation.

`include "ipfb_defs.svh"
module ipfb_filter_bind (
  // Clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic                hready,
  input  wire logic [31:0]         hwdata,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Raw filter results, same clock
  input  wire ipfb_pkg::ipfb_hit_t hit_v4,
  input  wire ipfb_pkg::ipfb_hit_t hit_v6,
  // Gated filter results
  output ipfb_pkg::ipfb_vec_t      pass_v4,
  output ipfb_pkg::ipfb_vec_t      pass_v6
);

  // Reset image: vectors clear, bus ready with OKAY
  localparam ipfb_pkg::ipfb_top_st_t ST_RST = '{
    bind4:     `IPFB_BIND_RST,
    bind6:     `IPFB_BIND_RST,
    pass4:     32'h0000_0000,
    pass6:     32'h0000_0000,
    hrdata:    32'h0000_0000,
    hreadyout: 1'b1,
    hresp:     `IPFB_RESP_OKAY
  };

  ipfb_pkg::ipfb_top_st_t st_r;
  ipfb_pkg::ipfb_top_st_t st_nxt;
  logic                   acc_rd;
  logic [7:0]             acc_idx;
  logic                   wr_pend;
  logic [7:0]             wr_idx;
  ipfb_pkg::ipfb_vec_t    gated4;
  ipfb_pkg::ipfb_vec_t    gated6;

  // Bus front end
  ipfb_ahb_front u_front (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hsel    (hsel),
    .haddr   (haddr),
    .htrans  (htrans),
    .hwrite  (hwrite),
    .hsize   (hsize),
    .hready  (hready),
    .acc_rd  (acc_rd),
    .acc_idx (acc_idx),
    .wr_pend (wr_pend),
    .wr_idx  (wr_idx)
  );

  // IPv4 host address binding
  ipfb_gate #(
    .W (32)
  ) u_gate_v4 (
    .en    (st_r.bind4),
    .hit   (hit_v4.hit),
    .match (hit_v4.addr_match),
    .pass  (gated4)
  );

  // IPv6 address binding
  ipfb_gate #(
    .W (32)
  ) u_gate_v6 (
    .en    (st_r.bind6),
    .hit   (hit_v6.hit),
    .match (hit_v6.addr_match),
    .pass  (gated6)
  );

  // Next state: register writes, readback, gated results
  always_comb begin
    st_nxt           = st_r;
    st_nxt.hreadyout = 1'b1;
    st_nxt.hresp     = `IPFB_RESP_OKAY;
    // Write data is taken in the data phase; reserved bits masked off
    if (wr_pend) begin
      case (wr_idx)
        `IPFB_IDX_V4_LO: begin
          st_nxt.bind4[15:0]  = hwdata[15:0] & `IPFB_V4_LO_MASK; // R10 R15
        end
        `IPFB_IDX_V4_HI: begin
          st_nxt.bind4[31:16] = hwdata[15:0] & `IPFB_V4_HI_MASK; // R10
        end
        `IPFB_IDX_V6_LO: begin
          st_nxt.bind6[15:0]  = hwdata[15:0] & `IPFB_V6_LO_MASK; // R11
        end
        `IPFB_IDX_V6_HI: begin
          st_nxt.bind6[31:16] = hwdata[15:0] & `IPFB_V6_HI_MASK; // R11
        end
        default: begin
          st_nxt.bind4 = st_r.bind4;
        end
      endcase
    end
    // Readback from the next value, so a read right after a write sees it
    if (acc_rd) begin
      case (acc_idx)
        `IPFB_IDX_V4_LO: begin
          st_nxt.hrdata = {16'h0000, st_nxt.bind4[15:0]}; // R10
        end
        `IPFB_IDX_V4_HI: begin
          st_nxt.hrdata = {16'h0000, st_nxt.bind4[31:16]}; // R10
        end
        `IPFB_IDX_V6_LO: begin
          st_nxt.hrdata = {16'h0000, st_nxt.bind6[15:0]}; // R11
        end
        `IPFB_IDX_V6_HI: begin
          st_nxt.hrdata = {16'h0000, st_nxt.bind6[31:16]}; // R11
        end
        default: begin
          st_nxt.hrdata = 32'h0000_0000; // Unmapped reads zero
        end
      endcase
    end
    // Gated verdicts, one cycle after the raw hits
    st_nxt.pass4 = gated4; // R01 R02 R03 R04 R05 R06 R07 R08 R09 R14
    st_nxt.pass6 = gated6; // R12 R13 R14
  end

  // State register; outputs come straight from it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ST_RST; // R15
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign hrdata    = st_r.hrdata;
  assign hreadyout = st_r.hreadyout;
  assign hresp     = st_r.hresp;
  assign pass_v4   = st_r.pass4;
  assign pass_v6   = st_r.pass6;

  // Assertion helpers: flattened views of the struct inputs and state
  ipfb_pkg::ipfb_vec_t hit4;
  ipfb_pkg::ipfb_vec_t hit6;
  logic                m4;
  logic                m6;
  ipfb_pkg::ipfb_vec_t bind4;
  ipfb_pkg::ipfb_vec_t bind6;

  assign hit4  = hit_v4.hit;
  assign hit6  = hit_v6.hit;
  assign m4    = hit_v4.addr_match;
  assign m6    = hit_v6.addr_match;
  assign bind4 = st_r.bind4;
  assign bind6 = st_r.bind6;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Bound TCP hits without an address match are dropped
  AST_V4_TCP_BLOCK: assert property ( // R01
    (|(bind4[10:0] & hit4[10:0]) && !m4) |=> ((pass_v4[10:0] & $past(bind4[10:0])) == 11'h0)
  ) else $error("bound ipv4 tcp hit passed without address match");

  // Bound TCP hits with a match pass
  AST_V4_TCP_PASS: assert property ( // R01
    m4 |=> (pass_v4[10:0] == $past(hit4[10:0]))
  ) else $error("ipv4 tcp hit lost despite address match");

  AST_V4_UDP: assert property ( // R02
    (bind4[12] && hit4[12] && !m4) |=> !pass_v4[12]
  ) else $error("bound first udp hit passed without match");

  AST_V4_EAP: assert property ( // R03
    (bind4[14] && hit4[14]) |=> (pass_v4[14] == $past(m4))
  ) else $error("eap over udp gating wrong");

  AST_V4_DNS: assert property ( // R04
    (bind4[15] && hit4[15] && !m4) |=> !pass_v4[15]
  ) else $error("bound name service hit passed without match");

  AST_V4_FLEX: assert property ( // R05
    (!m4) |=> ((pass_v4[27:16] & $past(bind4[27:16])) == 12'h000)
  ) else $error("bound flexible port hit passed without match");

  AST_V4_RANGE: assert property ( // R06
    (bind4[28] && hit4[28] && !m4) |=> !pass_v4[28]
  ) else $error("bound range port hit passed without match");

  AST_V4_ICMP: assert property ( // R07
    (bind4[29] && hit4[29] && !m4) |=> !pass_v4[29]
  ) else $error("bound icmpv4 hit passed without match");

  AST_V4_ARP: assert property ( // R08
    (bind4[30] && hit4[30]) |=> (pass_v4[30] == $past(m4))
  ) else $error("arp gating wrong");

  AST_V4_RMCP: assert property ( // R09
    (bind4[31] && hit4[31] && !m4) |=> !pass_v4[31]
  ) else $error("bound rmcp hit passed without match");

  // Write to the low IPv4 half lands, reserved bits held zero
  AST_V4_WRITE: assert property ( // R10
    (wr_pend && (wr_idx == `IPFB_IDX_V4_LO))
      |=> (bind4[15:0] == ($past(hwdata[15:0]) & `IPFB_V4_LO_MASK))
  ) else $error("ipv4 binding low half not written");

  // Write to the high IPv6 half lands, reserved bit held zero
  AST_V6_WRITE: assert property ( // R11
    (wr_pend && (wr_idx == `IPFB_IDX_V6_HI))
      |=> (bind6[31:16] == ($past(hwdata[15:0]) & `IPFB_V6_HI_MASK))
  ) else $error("ipv6 binding high half not written");

  AST_V6_TCP: assert property ( // R12
    (!m6) |=> ((pass_v6[8:0] & $past(bind6[8:0])) == 9'h0)
  ) else $error("bound ipv6 tcp hit passed without match");

  AST_V6_UPPER: assert property ( // R13
    (!m6) |=> ((pass_v6[31:9] & $past(bind6[31:9])) == 23'h0)
  ) else $error("bound ipv6 upper filter passed without match");

  // Unbound filters ignore the address verdict
  AST_UNBOUND: assert property ( // R14
    (bind4 == 32'h0000_0000) |=> (pass_v4 == $past(hit4))
  ) else $error("unbound ipv4 filter affected by address");

  AST_RESERVED: assert property ( // R15
    !bind4[11] && !bind4[13] && !bind6[11] && !bind6[30]
  ) else $error("reserved binding bit set");

  // Zero wait states; a master never has to stall on this slave
  AST_BUS_READY: assert property ( // R10 R11
    hreadyout
  ) else $error("slave inserted a wait state");

  AST_BUS_OKAY: assert property ( // R10 R11
    hresp == `IPFB_RESP_OKAY
  ) else $error("slave answered other than okay");

  // Halves are 16 bits wide; the top of the read word stays zero
  AST_HRDATA_TOP: assert property ( // R10 R11
    hrdata[31:16] == 16'h0000
  ) else $error("read data upper half not zero");

  // Read data holds until the next decoded read
  AST_HRDATA_HOLD: assert property ( // R10 R11
    !acc_rd |=> $stable(hrdata)
  ) else $error("read data changed without a read");

  // Each read returns the half it names, a write landing alongside included
  AST_V4_LO_READ: assert property ( // R10 R15
    (acc_rd && (acc_idx == `IPFB_IDX_V4_LO))
      |=> (hrdata == {16'h0000, bind4[15:0]})
  ) else $error("ipv4 binding low half read wrong");

  AST_V4_HI_READ: assert property ( // R10
    (acc_rd && (acc_idx == `IPFB_IDX_V4_HI))
      |=> (hrdata == {16'h0000, bind4[31:16]})
  ) else $error("ipv4 binding high half read wrong");

  AST_V6_LO_READ: assert property ( // R11 R15
    (acc_rd && (acc_idx == `IPFB_IDX_V6_LO))
      |=> (hrdata == {16'h0000, bind6[15:0]})
  ) else $error("ipv6 binding low half read wrong");

  AST_V6_HI_READ: assert property ( // R11 R15
    (acc_rd && (acc_idx == `IPFB_IDX_V6_HI))
      |=> (hrdata == {16'h0000, bind6[31:16]})
  ) else $error("ipv6 binding high half read wrong");

  // Unmapped aligned word reads in the low window answer zero rather than stale data
  AST_UNMAPPED_READ: assert property ( // R10 R11
    (acc_rd && (acc_idx != `IPFB_IDX_V4_LO) && (acc_idx != `IPFB_IDX_V4_HI)
      && (acc_idx != `IPFB_IDX_V6_LO) && (acc_idx != `IPFB_IDX_V6_HI))
      |=> (hrdata == 32'h0000_0000)
  ) else $error("unmapped read returned data");

  // The other two halves land the same way
  AST_V4_HI_WRITE: assert property ( // R10
    (wr_pend && (wr_idx == `IPFB_IDX_V4_HI))
      |=> (bind4[31:16] == ($past(hwdata[15:0]) & `IPFB_V4_HI_MASK))
  ) else $error("ipv4 binding high half not written");

  AST_V6_LO_WRITE: assert property ( // R11 R15
    (wr_pend && (wr_idx == `IPFB_IDX_V6_LO))
      |=> (bind6[15:0] == ($past(hwdata[15:0]) & `IPFB_V6_LO_MASK))
  ) else $error("ipv6 binding low half not written");

  // Refused accesses leave no pending write, so the vectors must hold
  AST_IDLE_HOLD: assert property ( // R10 R11
    !wr_pend |=> ($stable(bind4) && $stable(bind6))
  ) else $error("binding vector changed without a write");

  // An address match lets every hit through, bound or not
  AST_V4_MATCH_PASS: assert property ( // R05 R06 R07 R08 R09
    m4 |=> (pass_v4 == $past(hit4))
  ) else $error("ipv4 hit lost despite address match");

  AST_V6_MATCH_PASS: assert property ( // R12 R13
    m6 |=> (pass_v6 == $past(hit6))
  ) else $error("ipv6 hit lost despite address match");

  // Clear enable bits pass their hits whatever the address verdict
  AST_UNBOUND_V4_BITS: assert property ( // R14
    1'b1 |=> ((pass_v4 & ~$past(bind4)) == ($past(hit4) & ~$past(bind4)))
  ) else $error("unbound ipv4 filter bit affected by address");

  AST_UNBOUND_V6_BITS: assert property ( // R14
    1'b1 |=> ((pass_v6 & ~$past(bind6)) == ($past(hit6) & ~$past(bind6)))
  ) else $error("unbound ipv6 filter bit affected by address");

  AST_V6_DHCP: assert property ( // R13
    (bind6[`IPFB_DHCP6] && hit6[`IPFB_DHCP6] && !m6) |=> !pass_v6[`IPFB_DHCP6]
  ) else $error("bound dhcpv6 hit passed without match");

  AST_V6_ICMP: assert property ( // R13
    (bind6[`IPFB_ICMP] && hit6[`IPFB_ICMP] && !m6) |=> !pass_v6[`IPFB_ICMP]
  ) else $error("bound icmpv6 hit passed without match");

  AST_V6_RMCP: assert property ( // R13
    (bind6[`IPFB_RMCP] && hit6[`IPFB_RMCP] && !m6) |=> !pass_v6[`IPFB_RMCP]
  ) else $error("bound ipv6 rmcp hit passed without match");

  // Main scenarios
  COV_V4_WRITE: cover property (wr_pend && (wr_idx == `IPFB_IDX_V4_HI));
  COV_V4_DROP: cover property ((bind4 & hit4) != 32'h0000_0000 && !m4);
  COV_V6_DROP: cover property ((bind6 & hit6) != 32'h0000_0000 && !m6);
  COV_READ: cover property (acc_rd && (acc_idx == `IPFB_IDX_V6_LO));
  COV_V4_PASS: cover property (m4 && ((bind4 & hit4) != 32'h0000_0000));

endmodule

// file: hw/ipfb_gate.sv
// Gates a vector of filter hits with an address match under per-bit enables
module ipfb_gate #(
  parameter int W = 32
) (
  // Enables and hits
  input  wire logic [W-1:0] en,
  input  wire logic [W-1:0] hit,
  // Address filter verdict
  input  wire logic         match,
  // Gated result
  output logic      [W-1:0] pass
);

  // Enabled bits need the address match; clear bits pass the hit unchanged
  assign pass = hit & (~en | {W{match}});

endmodule

// file: hw/ipfb_pkg.sv
// Types shared by the binding block modules
package ipfb_pkg;

  // One binding or filter-result vector
  typedef logic [31:0] ipfb_vec_t;

  // Raw port/protocol filter hits with the address filter verdict
  typedef struct packed {
    logic      addr_match;
    ipfb_vec_t hit;
  } ipfb_hit_t;

  // Bus front-end state: pending write data phase
  typedef struct packed {
    logic       wr_pend;
    logic [7:0] wr_idx;
  } ipfb_bus_st_t;

  // Top-level state
  typedef struct packed {
    ipfb_vec_t   bind4;
    ipfb_vec_t   bind6;
    ipfb_vec_t   pass4;
    ipfb_vec_t   pass6;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ipfb_top_st_t;

endpackage
